/* File: logic/ddrm_top.sv */
// Behaviour
// - Commands sampled on true clock rising edges
// - Writes captured both strobe edges; reads launched both
// - Read strobe edge aligned; write strobe centered
// - Two strobes per chip, one per byte
// - One core word per clock, two pin halves
// - Activate picks bank and row; column later
// - Four banks open and close independently
// - Burst length 2, 4 or 8 everywhere
// - Auto precharge closes row after burst
// - Data pins released until first read
// - Mode register holds until rewritten, save loop reset bit
// - Loop reset bit clears itself
// - Mode writes leave array untouched
// - Fields: length, type, latency, operating mode
// - Burst wraps inside aligned block
// - Order bit picks sequential or interleaved
// - Read latency two or two and half
// - Zero mode normal; loop reset; others reserved
`timescale 1ns/1ps
`default_nettype none
module ddrm_top
   import ddrm_pkg::*;
#(
   parameter int DQ_W = 16,
   parameter int AW = MEM_AW
) (
   // System
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Link clock and command pins
   input wire logic CK,
   input wire logic CLOCK_COMPLEMENT,
   input wire logic CKE,
   input wire logic CS_B,
   input wire logic RAS_B,
   input wire logic CAS_B,
   input wire logic WE_B,
   input wire logic BANK_SELECT_LOW,
   input wire logic BANK_SELECT_HIGH,
   input wire logic [ROW_W-1:0] ADDR,
   // Data, mask and strobes
   input wire logic [DQ_W-1:0] DQ_IN,
   output logic [DQ_W-1:0] DQ_OUT,
   output logic DQ_OE_B,
   input wire logic [DQ_W/8-1:0] WRITE_BYTE_MASK,
   input wire logic [DQ_W/8-1:0] DQS_IN,
   output logic [DQ_W/8-1:0] DQS_OUT,
   output logic DQS_OE_B,
   // Status
   output logic [MR_WIDTH-1:0] OPERATING_PARAMETER,
   output logic [NUM_BANKS-1:0] BANK_OPEN,
   output logic LOOP_RESET_DONE
);
   localparam int NS = DQ_W/8;
   localparam int DW = 2*DQ_W;
   localparam int SYNC_W = 7 + ROW_W + 2 + DQ_W + 2*NS;
   localparam logic [7:0] LOOP_LOCK_CLKS = 8'hC8;

   typedef enum logic [2:0] {
      DDRM_IDLE = 3'b001,
      DDRM_READ = 3'b010,
      DDRM_WRITE = 3'b100
   } ddrm_state_t;

   // Two-flop synchroniser for every pin input
   logic [SYNC_W-1:0] s1_r, s2_r, pin_in;
   assign pin_in = {CK, CLOCK_COMPLEMENT, CKE, CS_B, RAS_B, CAS_B, WE_B,
                    BANK_SELECT_HIGH, BANK_SELECT_LOW, ADDR, DQ_IN,
                    WRITE_BYTE_MASK, DQS_IN};
   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
      end
   end
   logic ck_s, ckn_s, cke_s;
   logic [3:0] cmd_s;
   logic [1:0] ba_s;
   logic [ROW_W-1:0] a_s;
   logic [DQ_W-1:0] dq_s;
   logic [NS-1:0] dm_s, dqs_s;
   assign {ck_s, ckn_s, cke_s, cmd_s, ba_s, a_s, dq_s, dm_s, dqs_s} = s2_r;

   // Edge detection on the synchronised link clock and strobes
   logic ck_d_r, ck_d_nxt;
   logic [NS-1:0] dqs_d_r, dqs_d_nxt;
   logic ck_rise, ck_fall;
   logic [NS-1:0] dqs_edge;
   assign ck_d_nxt = ck_s;
   assign dqs_d_nxt = dqs_s;
   assign ck_rise = ck_s & !ck_d_r & !ckn_s;
   assign ck_fall = !ck_s & ck_d_r;
   assign dqs_edge = dqs_s ^ dqs_d_r;

   // Command state
   logic [MR_WIDTH-1:0] mr_r, mr_nxt;
   logic [NUM_BANKS-1:0] open_r, open_nxt;
   logic [ROW_W-1:0] row_r [NUM_BANKS];
   logic [ROW_W-1:0] row_nxt [NUM_BANKS];
   ddrm_state_t st_r, st_nxt;
   logic [2:0] beat_r, beat_nxt;
   logic [2:0] start_r, start_nxt;
   logic [COL_W-1:0] col_r, col_nxt;
   logic [1:0] bank_r, bank_nxt;
   logic ap_r, ap_nxt;
   logic [2:0] lat_r, lat_nxt;
   logic half_r, half_nxt;
   logic drive_r, drive_nxt;
   logic [7:0] lock_r, lock_nxt;
   logic [DQ_W-1:0] lo_r, lo_nxt;
   logic [DQ_W-1:0] dq_out_r, dq_out_nxt;
   logic [NS-1:0] dqs_out_r, dqs_out_nxt;
   logic wr_go;
   logic [NS-1:0] lo_dm_r, lo_dm_nxt;

   // Burst length minus one: last beat and block mask
   logic [2:0] blen_m1;
   always_comb begin
      case (mr_r[MR_BL_LSB +: 3])
         BL_CODE_2: blen_m1 = 3'h1;
         BL_CODE_4: blen_m1 = 3'h3;
         BL_CODE_8: blen_m1 = 3'h7;
         default: blen_m1 = 3'h1;
      endcase
   end

   // Column of current beat, wrapped within block
   logic [2:0] ofs;
   logic [COL_W-1:0] beat_col;
   always_comb begin
      if (mr_r[MR_BT_BIT]) begin
         ofs = start_r ^ beat_r;
      end else begin
         ofs = start_r + beat_r;
      end
      beat_col = (col_r & ~{{(COL_W-3){1'b0}}, blen_m1})
                 | {{(COL_W-3){1'b0}}, ofs & blen_m1};
   end

   logic [AW-1:0] mem_addr;
   logic [DW-1:0] rdata;
   logic [DW-1:0] wdata;
   logic [DW/8-1:0] wmask_b;
   assign mem_addr = AW'({bank_r, row_r[bank_r][1:0], beat_col});
   assign wdata = {dq_s, lo_r};
   assign wmask_b = {~dm_s, ~lo_dm_r};

   ddrm_array #(.AW(AW), .DW(DW)) u_array (
      .clk(CLK_SYS),
      .we(wr_go),
      .waddr(mem_addr),
      .wdata(wdata),
      .wmask_b(wmask_b),
      .raddr(mem_addr),
      .rdata(rdata)
   );

   always_comb begin
      mr_nxt = mr_r;
      open_nxt = open_r;
      row_nxt = row_r;
      st_nxt = st_r;
      beat_nxt = beat_r;
      start_nxt = start_r;
      col_nxt = col_r;
      bank_nxt = bank_r;
      ap_nxt = ap_r;
      lat_nxt = lat_r;
      half_nxt = half_r;
      drive_nxt = drive_r;
      lock_nxt = lock_r;
      lo_nxt = lo_r;
      dq_out_nxt = dq_out_r;
      dqs_out_nxt = dqs_out_r;
      lo_dm_nxt = lo_dm_r;
      wr_go = 1'b0;
      if (mr_r[MR_LOOP_RESET_BIT]) begin
         mr_nxt[MR_LOOP_RESET_BIT] = 1'b0;
      end
      if (ck_rise && lock_r != LOOP_LOCK_CLKS) begin
         lock_nxt = lock_r + 8'h01;
      end
      // Commands only on rising link clock with clock gate high
      if (ck_rise && cke_s) begin
         case (cmd_s)
            CMD_MRS: begin
               if (ba_s == 2'h0 && open_r == '0 && st_r == DDRM_IDLE) begin
                  mr_nxt = a_s;
                  if (a_s[MR_OP_LSB +: 6] == OP_LOOP_RESET) begin
                     lock_nxt = 8'h00;
                  end
               end
            end
            CMD_ACT: begin
               open_nxt[ba_s] = 1'b1;
               row_nxt[ba_s] = a_s;
            end
            CMD_PRE: begin
               if (a_s[AP_BIT]) begin
                  open_nxt = '0;
               end else begin
                  open_nxt[ba_s] = 1'b0;
               end
            end
            CMD_RD, CMD_WR: begin
               if (open_r[ba_s] && st_r == DDRM_IDLE) begin
                  bank_nxt = ba_s;
                  col_nxt = a_s[COL_W-1:0];
                  start_nxt = a_s[2:0];
                  ap_nxt = a_s[AP_BIT];
                  beat_nxt = 3'h0;
                  // Counted in link edges: four or five halves
                  lat_nxt = mr_r[MR_CL_LSB +: 3] == CL_CODE_25 ? 3'h5
                                                               : 3'h4;
                  half_nxt = 1'b0;
                  st_nxt = cmd_s == CMD_RD ? DDRM_READ : DDRM_WRITE;
               end
            end
            default: begin
            end
         endcase
      end
      case (st_r)
         DDRM_READ: begin
            if (ck_rise || ck_fall) begin
               if (lat_r != 3'h0) begin
                  lat_nxt = lat_r - 3'h1;
               end
               if (lat_r <= 3'h1) begin
                  // Edge-aligned: data and strobe flip together
                  drive_nxt = 1'b1;
                  dq_out_nxt = half_r ? rdata[DW-1:DQ_W]
                                      : rdata[DQ_W-1:0];
                  dqs_out_nxt = {NS{~half_r}};
                  half_nxt = ~half_r;
                  if (half_r) begin
                     if (beat_r == blen_m1) begin
                        st_nxt = DDRM_IDLE;
                        if (ap_r) begin
                           open_nxt[bank_r] = 1'b0;
                        end
                     end else begin
                        beat_nxt = beat_r + 3'h1;
                     end
                  end
               end
            end
         end
         DDRM_WRITE: begin
            if (dqs_edge != '0) begin
               // Centered strobe, so sampled data are settled
               if (!half_r) begin
                  lo_nxt = dq_s;
                  lo_dm_nxt = dm_s;
               end else begin
                  wr_go = 1'b1;
                  if (beat_r == blen_m1) begin
                     st_nxt = DDRM_IDLE;
                     if (ap_r) begin
                        open_nxt[bank_r] = 1'b0;
                     end
                  end else begin
                     beat_nxt = beat_r + 3'h1;
                  end
               end
               half_nxt = ~half_r;
            end
         end
         default: begin
            if (drive_r && (ck_rise || ck_fall)) begin
               drive_nxt = 1'b0;
               dqs_out_nxt = '0;
            end
         end
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RST_B) begin
      if (!RST_B) begin
         ck_d_r <= 1'b0;
         dqs_d_r <= '0;
         mr_r <= MR_RESET;
         open_r <= '0;
         for (int i = 0; i < NUM_BANKS; i++) begin
            row_r[i] <= '0;
         end
         st_r <= DDRM_IDLE;
         beat_r <= 3'h0;
         start_r <= 3'h0;
         col_r <= '0;
         bank_r <= 2'h0;
         ap_r <= 1'b0;
         lat_r <= 3'h0;
         half_r <= 1'b0;
         drive_r <= 1'b0;
         lock_r <= 8'h00;
         lo_r <= '0;
         lo_dm_r <= '0;
         dq_out_r <= '0;
         dqs_out_r <= '0;
      end else begin
         ck_d_r <= ck_d_nxt;
         dqs_d_r <= dqs_d_nxt;
         mr_r <= mr_nxt;
         open_r <= open_nxt;
         row_r <= row_nxt;
         st_r <= st_nxt;
         beat_r <= beat_nxt;
         start_r <= start_nxt;
         col_r <= col_nxt;
         bank_r <= bank_nxt;
         ap_r <= ap_nxt;
         lat_r <= lat_nxt;
         half_r <= half_nxt;
         drive_r <= drive_nxt;
         lock_r <= lock_nxt;
         lo_r <= lo_nxt;
         lo_dm_r <= lo_dm_nxt;
         dq_out_r <= dq_out_nxt;
         dqs_out_r <= dqs_out_nxt;
      end
   end

   // Pins released from reset until a read drives them
   assign DQ_OUT = dq_out_r;
   assign DQS_OUT = dqs_out_r;
   assign DQ_OE_B = ~drive_r;
   assign DQS_OE_B = ~drive_r;
   assign OPERATING_PARAMETER = mr_r;
   assign BANK_OPEN = open_r;
   assign LOOP_RESET_DONE = lock_r == LOOP_LOCK_CLKS;
endmodule // ddrm_top
`default_nettype wire

/* File: include/ddrm_pkg.sv */
package ddrm_pkg;
   // Command codes {cs_b, ras_b, cas_b, we_b}
   localparam logic [3:0] CMD_MRS = 4'h0;
   localparam logic [3:0] CMD_REF = 4'h1;
   localparam logic [3:0] CMD_PRE = 4'h2;
   localparam logic [3:0] CMD_ACT = 4'h3;
   localparam logic [3:0] CMD_WR = 4'h4;
   localparam logic [3:0] CMD_RD = 4'h5;
   localparam logic [3:0] CMD_NOP = 4'h7;
   // Mode register fields
   localparam int MR_BL_LSB = 0;
   localparam int MR_BT_BIT = 3;
   localparam int MR_CL_LSB = 4;
   localparam int MR_OP_LSB = 7;
   localparam int MR_LOOP_RESET_BIT = 8;
   localparam int MR_WIDTH = 13;
   localparam logic [12:0] MR_RESET = 13'h0000;
   // Burst length codes
   localparam logic [2:0] BL_CODE_2 = 3'h1;
   localparam logic [2:0] BL_CODE_4 = 3'h2;
   localparam logic [2:0] BL_CODE_8 = 3'h3;
   // Read latency codes (2 and 2.5 link clocks)
   localparam logic [2:0] CL_CODE_2 = 3'h2;
   localparam logic [2:0] CL_CODE_25 = 3'h6;
   localparam logic [5:0] OP_NORMAL = 6'h00;
   localparam logic [5:0] OP_LOOP_RESET = 6'h02;
   localparam int AP_BIT = 10;
   localparam int NUM_BANKS = 4;
   localparam int COL_W = 10;
   localparam int ROW_W = 13;
   localparam int MEM_AW = 8;
endpackage

/* File: logic/ddrm_array.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrm_array #(
   parameter int AW = 8,
   parameter int DW = 32
) (
   input wire logic clk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [DW/8-1:0] wmask_b,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk) begin
      if (we) begin
         for (int i = 0; i < DW/8; i++) begin
            if (wmask_b[i]) begin
               mem[waddr][i*8 +: 8] <= wdata[i*8 +: 8];
            end
         end
      end
      rdata <= mem[raddr];
   end
endmodule // ddrm_array
`default_nettype wire

/* File: testbench/ddrm_chk_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrm_chk
   import ddrm_pkg::*;
#(
   parameter int DQ_W = 16
) (
   // System
   input wire logic CLK_SYS,
   input wire logic RST_B,
   // Read side
   input wire logic [DQ_W-1:0] DQ_OUT,
   input wire logic DQ_OE_B,
   input wire logic [DQ_W/8-1:0] DQS_OUT,
   input wire logic DQS_OE_B,
   // Status
   input wire logic [MR_WIDTH-1:0] OPERATING_PARAMETER,
   input wire logic [NUM_BANKS-1:0] BANK_OPEN,
   input wire logic LOOP_RESET_DONE
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RST_B);
   chk_loop_bit_clears: assert property (
      OPERATING_PARAMETER[MR_LOOP_RESET_BIT]
      |-> ##[1:8] !OPERATING_PARAMETER[MR_LOOP_RESET_BIT])
      else $error("loop reset bit stuck");
   chk_mode_when_idle: assert property (
      $changed(OPERATING_PARAMETER) |-> BANK_OPEN == '0)
      else $error("mode changed with a bank open");
   chk_release_state: assert property (
      $rose(RST_B) |-> DQ_OE_B && DQS_OE_B && !LOOP_RESET_DONE
      && OPERATING_PARAMETER == MR_RESET && BANK_OPEN == '0)
      else $error("state after reset wrong");
   chk_burst_min_len: assert property (
      $fell(DQ_OE_B) |-> !DQ_OE_B [*8])
      else $error("read burst too short");
   chk_strobe_pair: assert property (
      !DQS_OE_B |-> DQS_OUT == {(DQ_W/8){DQS_OUT[0]}})
      else $error("byte strobes differ");
   chk_data_has_strobe: assert property (
      !DQ_OE_B |-> !DQS_OE_B)
      else $error("data driven without strobe");
   chk_strobe_moves: assert property (
      !DQ_OE_B |-> ##[0:12] ($changed(DQS_OUT) || DQ_OE_B))
      else $error("read strobe stalled");
   chk_data_edge_aligned: assert property (
      !DQ_OE_B && !$past(DQ_OE_B) && $changed(DQ_OUT)
      |-> $changed(DQS_OUT))
      else $error("read data off strobe edge");
endmodule // ddrm_chk
bind ddrm_top ddrm_chk #(.DQ_W(DQ_W)) u_chk (.CLK_SYS(CLK_SYS),
   .RST_B(RST_B), .DQ_OUT(DQ_OUT), .DQ_OE_B(DQ_OE_B),
   .DQS_OUT(DQS_OUT), .DQS_OE_B(DQS_OE_B),
   .OPERATING_PARAMETER(OPERATING_PARAMETER),
   .BANK_OPEN(BANK_OPEN), .LOOP_RESET_DONE(LOOP_RESET_DONE));
`default_nettype wire

/* File: testbench/ddrm_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrm_ctrl_model
   import ddrm_pkg::*;
#(
   parameter int REFRESH_CYCLE_TIME = 10
) (
   // Link clock and command
   output logic ck,
   output logic clock_complement,
   output logic cke,
   output logic [3:0] cmd,
   output logic [1:0] ba,
   output logic [12:0] addr,
   // Write data
   output logic [15:0] dq,
   output logic [1:0] write_byte_mask,
   output logic [1:0] dqs
);
   initial begin
      ck = 1'b0;
      clock_complement = 1'b1;
      cke = 1'b0;
      cmd = 4'hF;
      ba = 2'h0;
      addr = 13'h0000;
      dq = 16'h0000;
      write_byte_mask = 2'h3;
      dqs = 2'h3;
      #3;
      // Free running, phase unrelated to the system clock
      forever begin
         #40;
         ck = ~ck;
         clock_complement = ~ck;
      end
   end
   task automatic issue(input logic [3:0] c, input logic [1:0] b,
                        input logic [12:0] a);
      @(negedge ck);
      cmd <= c;
      ba <= b;
      addr <= a;
      @(negedge ck);
      cmd <= CMD_NOP;
      ba <= ~b;
      addr <= ~a;
   endtask
   task automatic write_burst(input logic [12:0] a, input int beats,
                              input logic [1:0] m, input logic [15:0] x);
      logic [3:0] c;
      @(negedge ck);
      cmd <= CMD_WR;
      ba <= 2'h0;
      addr <= a;
      @(posedge ck);
      for (int h = 0; h < 2 * beats; h++) begin
         c = a[3:0] + 4'(h / 2);
         dq <= x ^ (h[0] ? {12'h220, c} : {12'h110, c});
         write_byte_mask <= m;
         #20;
         dqs <= ~dqs;
         cmd <= CMD_NOP;
         #20;
      end
      dq <= ~dq;
      write_byte_mask <= ~m;
      @(negedge ck);
   endtask
   task automatic init_loop(input logic [12:0] v);
      #200000;
      issue(CMD_NOP, 2'h0, 13'h0000);
      cke <= 1'b1;
      issue(CMD_PRE, 2'h0, 13'h0400);
      issue(CMD_MRS, 2'h1, 13'h0000);
      issue(CMD_MRS, 2'h0, v);
   endtask
   task automatic init_finish(input logic [12:0] v);
      issue(CMD_PRE, 2'h0, 13'h0400);
      repeat (2) begin
         issue(CMD_REF, 2'h0, 13'h0000);
         repeat (REFRESH_CYCLE_TIME) @(negedge ck);
      end
      issue(CMD_MRS, 2'h0, v);
      repeat (200) @(posedge ck);
   endtask
endmodule // ddrm_ctrl_model
`default_nettype wire

/* File: testbench/ddrm_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module ddrm_top_test;
   import ddrm_pkg::*;
   logic clk_sys;
   logic rst_b;
   wire ck, ck_c, cke;
   wire [3:0] cmd;
   wire [1:0] ba, wbm, dqs_in;
   wire [12:0] addr;
   wire [15:0] dq_in;
   logic [15:0] dq_out;
   logic [1:0] dqs_out;
   logic [12:0] op;
   logic [3:0] bank_open;
   logic dq_oe_b, dqs_oe_b, loop_done;
   int n_fail = 0;
   int n_compared = 0;
   // {latency, order, length, start column}
   logic [10:0] rows [6] = '{{CL_CODE_2, 1'b0, BL_CODE_2, 4'h1},
      {CL_CODE_25, 1'b0, BL_CODE_4, 4'h3}, {CL_CODE_2, 1'b1, BL_CODE_4, 4'h1},
      {CL_CODE_25, 1'b0, BL_CODE_8, 4'h5}, {CL_CODE_2, 1'b1, BL_CODE_8, 4'h6},
      {CL_CODE_25, 1'b1, BL_CODE_2, 4'h7}};
   ddrm_top dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .CK(ck),
      .CLOCK_COMPLEMENT(ck_c), .CKE(cke), .CS_B(cmd[3]), .RAS_B(cmd[2]),
      .CAS_B(cmd[1]), .WE_B(cmd[0]), .BANK_SELECT_LOW(ba[0]),
      .BANK_SELECT_HIGH(ba[1]), .ADDR(addr), .DQ_IN(dq_in), .DQ_OUT(dq_out),
      .DQ_OE_B(dq_oe_b), .WRITE_BYTE_MASK(wbm), .DQS_IN(dqs_in),
      .DQS_OUT(dqs_out), .DQS_OE_B(dqs_oe_b), .OPERATING_PARAMETER(op),
      .BANK_OPEN(bank_open), .LOOP_RESET_DONE(loop_done));
   ddrm_ctrl_model p (.ck(ck), .clock_complement(ck_c), .cke(cke),
      .cmd(cmd), .ba(ba), .addr(addr), .dq(dq_in), .write_byte_mask(wbm),
      .dqs(dqs_in));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic settle();
      repeat (12) @(negedge clk_sys);
   endtask
   task automatic wait_oe(input logic v);
      for (int k = 0; k < 100 && dq_oe_b !== v; k++) @(negedge clk_sys);
   endtask
   // Reads with auto precharge, so the bank must close after
   task automatic read_burst(input logic [12:0] a, input int bl,
                             input logic il, input logic cl25,
                             input logic [15:0] x);
      logic [3:0] c;
      logic [3:0] j;
      int n;
      p.issue(CMD_RD, 2'h0, a);
      // Link half is 5 system clocks; sync costs 2 of them
      for (n = 0; n < 100 && dq_oe_b !== 1'b0; n++) @(negedge clk_sys);
      check(16'(n), cl25 ? 16'h0017 : 16'h0012);
      for (int h = 0; h < 2 * bl; h++) begin
         for (int k = 0; k < 12 && dqs_out[0] !== !h[0]; k++) begin
            @(negedge clk_sys);
         end
         @(negedge clk_sys);
         j = 4'(h / 2);
         c = il ? a[3:0] ^ j : (a[3:0] & ~4'(bl - 1)) |
             ((a[3:0] + j) & 4'(bl - 1));
         check(dq_out, x ^ (h[0] ? {12'h220, c} : {12'h110, c}));
         check(dqs_out, h[0] ? 16'h0000 : 16'h0003);
      end
      wait_oe(1'b1);
      check(dq_oe_b, 16'h0001);
      settle();
      check(bank_open, 16'h0000);
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial begin
      #600000;
      n_fail++;
      finish_test();
   end
   initial begin
      rst_b = 1'b0;
      repeat (10) @(posedge clk_sys);
      rst_b <= 1'b1;
      p.init_loop({OP_LOOP_RESET, CL_CODE_2, 1'b0, BL_CODE_8});
      settle();
      check(op, {OP_NORMAL, CL_CODE_2, 1'b0, BL_CODE_8});
      check(loop_done, 16'h0000);
      check({dq_oe_b, dqs_oe_b}, 16'h0003);
      p.init_finish({OP_NORMAL, CL_CODE_2, 1'b0, BL_CODE_8});
      settle();
      check(loop_done, 16'h0001);
      p.issue(CMD_ACT, 2'h0, 13'h0000);
      p.issue(CMD_ACT, 2'h2, 13'h1FFF);
      settle();
      check(bank_open, 16'h0005);
      p.issue(CMD_PRE, 2'h2, 13'h0000);
      settle();
      check(bank_open, 16'h0001);
      p.write_burst(13'h0400, 8, 2'h0, 16'h0000);
      settle();
      check(bank_open, 16'h0000);
      foreach (rows[i]) begin
         p.issue(CMD_MRS, 2'h0, {OP_NORMAL, rows[i][10:4]});
         settle();
         check(op, {OP_NORMAL, rows[i][10:4]});
         p.issue(CMD_ACT, 2'h0, 13'h0000);
         read_burst(13'h0400 | 13'(rows[i][3:0]), 1 << rows[i][6:4],
                    rows[i][7], rows[i][10:8] == CL_CODE_25,
                    16'h0000);
      end
      // Low byte masked: only the high byte may change
      p.issue(CMD_ACT, 2'h0, 13'h0000);
      p.write_burst(13'h0400, 2, 2'h1, 16'hFFFF);
      p.issue(CMD_ACT, 2'h0, 13'h0000);
      read_burst(13'h0400, 2, 1'b1, 1'b1, 16'hFF00);
      p.issue(CMD_MRS, 2'h1, 13'h1FFF);
      settle();
      check(op, {OP_NORMAL, rows[5][10:4]});
      p.issue(CMD_ACT, 2'h1, 13'h0000);
      // Mode load with a bank open must be refused
      p.issue(CMD_MRS, 2'h0, 13'h0000);
      settle();
      check(op, {OP_NORMAL, rows[5][10:4]});
      check(bank_open, 16'h0002);
      @(posedge clk_sys);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      check({op, bank_open[2:0]}, 16'h0000);
      check({dq_oe_b, loop_done}, 16'h0002);
      rst_b <= 1'b1;
      finish_test();
   end
endmodule // ddrm_top_test
`default_nettype wire
